/* File: rtl/rfoc_core.sv */
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "rfoc_consts.svh"

// Operation
// - Inhibit inputs have selectable active level
// - Any active inhibit holds amplifier off
// - Inhibits work in local and maintenance
// - Inhibits cleared: on unless muted or maintenance
// - Maintenance clear forces mute; local operate only
// - Inhibit contact de-energized while inhibited
// - Power-up: muted, operating or previous
// - Other off conditions override power-up choice
// - Restore-previous writes every mute change
// - Gain -20.0 to 0.0 dB, 0.1 steps
// - Increment at 0.0 dB leaves gain
// - First gain press opens screen; 5 s return
// - Switch status reported as six states
// - Switch commands from menu/serial, not contacts
// - RF status off when anything turns off
// - Off status carries its reason
// - Maintenance forced mute reports contact input
// - Fitted upconverter unlock turns amplifier off
// - RF-on indicator lit exactly when on
// - Default display: power if on, else reason
// - Mute contacts act on edges only
module rfoc_core #(
  parameter logic [26:0] GAIN_TMO_CYC = 27'(`RFOC_GAIN_TMO_S * `RFOC_CLK_HZ)
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Parallel contact inputs
  input wire logic [3:0] i_contact_in,
  // Local panel keys, one-cycle pulses
  input wire rfoc_pkg::rfoc_keys_t i_keys,
  // Amplifier shutdown conditions
  input wire rfoc_pkg::rfoc_shut_t i_shut,
  // Output path switch sense
  input wire rfoc_pkg::rfoc_sw_sense_t i_sw_sense,
  // Nonvolatile settings seen at power-up
  input wire logic [1:0] i_nv_pwrup_mode,
  input wire logic i_nv_mute_prev,
  // Outputs
  output logic o_amp_enable,
  output logic o_rf_on_led,
  output logic o_mute_led,
  output logic o_inhibit_contact,
  output logic [3:0] o_off_reason,
  output logic o_show_power,
  output logic o_gain_screen,
  output logic [7:0] o_gain_atten,
  output logic o_switch_to_load,
  output logic o_nv_wr,
  output logic o_nv_mute
);

  rfoc_pkg::rfoc_st_t st_ff; // All block state
  rfoc_pkg::rfoc_st_t nxt_st; // Next block state

  logic [3:0] in_act; // Input at its active level
  logic [3:0] in_fall; // Input falling edges
  logic [3:0] in_rise; // Input rising edges
  logic gain_tmo; // Gain screen idle expiry
  logic any_inhibit; // Any inhibit input active
  logic any_shut; // Any shutdown condition
  rfoc_pkg::rfoc_sw_t sw_status; // Decoded switch status

  ////////////////////////////////////////////////////////////////////////
  // Contact input conditioners
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cin
      rfoc_contact_in u_cin (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_pin(i_contact_in[gi]),
        .i_active_low(st_ff.in_low[gi]),
        .o_active(in_act[gi]),
        .o_fall(in_fall[gi]),
        .o_rise(in_rise[gi])
      );
    end
  endgenerate

  // Gain screen inactivity timer
  rfoc_idle_timer #(
    .LIMIT(GAIN_TMO_CYC)
  ) u_gain_tmr (
    .i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n),
    .i_clk_en(i_clk_en),
    .i_run(st_ff.scr == rfoc_pkg::SCR_GAIN),
    .i_kick(i_keys.gain_up | i_keys.gain_down),
    .o_expired(gain_tmo)
  );

  ////////////////////////////////////////////////////////////////////////
  // Inhibit summary, level sensitive in every control mode
  always_comb begin
    any_inhibit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (st_ff.in_fn[3*i +: 3] == `RFOC_FN_INHIBIT && in_act[i]) begin
        any_inhibit = 1'b1;
      end
    end
  end

  // Shutdowns; upconverter counts only when fitted
  assign any_shut = (i_shut.upconverter_unlock & st_ff.buc_fitted)
                  | i_shut.thermal_shutdown | i_shut.interlock_broken
                  | i_shut.fast_shutoff_short | i_shut.gate_bias_failure
                  | i_shut.overcurrent_shutdown;

  ////////////////////////////////////////////////////////////////////////
  // Switch status decode, error sense first
  always_comb begin
    if (i_sw_sense.hw_error) begin
      sw_status = rfoc_pkg::SW_SWITCH_STATUS_UNREADABLE;
    end else if (!i_sw_sense.present) begin
      sw_status = rfoc_pkg::SW_DISCONNECTED;
    end else if (!i_sw_sense.power_ok) begin
      sw_status = rfoc_pkg::SW_SWITCH_POWER_FAILED;
    end else if (i_sw_sense.at_antenna && !i_sw_sense.at_load) begin
      sw_status = rfoc_pkg::SW_ANTENNA;
    end else if (i_sw_sense.at_load && !i_sw_sense.at_antenna) begin
      sw_status = rfoc_pkg::SW_LOAD_POSITION;
    end else begin
      sw_status = rfoc_pkg::SW_SWITCHING;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read view of a given address
  function automatic logic [31:0] rd_val(input logic [7:0] a, input rfoc_pkg::rfoc_st_t s,
                                         input rfoc_pkg::rfoc_sw_t sw, input logic inh);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      `RFOC_OFS_CTRL: begin
        v[`RFOC_CTRL_MAINT] = s.maint;
        v[`RFOC_CTRL_PWRUP_LO +: 2] = s.pwrup;
        v[`RFOC_CTRL_BUC] = s.buc_fitted;
      end
      `RFOC_OFS_MUTE: v[0] = s.mute;
      `RFOC_OFS_INCFG: begin
        v[11:0] = s.in_fn;
        v[`RFOC_INCFG_POL_LO +: 4] = s.in_low;
      end
      `RFOC_OFS_GAIN: v[7:0] = s.atten;
      `RFOC_OFS_STATUS: begin
        v[`RFOC_ST_RFON] = s.amp_en;
        v[`RFOC_ST_REASON_LO +: 4] = s.reason;
        v[`RFOC_ST_SWITCH_LO +: 3] = sw;
        v[`RFOC_ST_INHIBIT] = inh;
        v[`RFOC_ST_GAINSCR] = (s.scr == rfoc_pkg::SCR_GAIN);
        v[`RFOC_ST_MUTESRC_LO +: 2] = s.mute_src;
      end
      `RFOC_OFS_SWCMD: v[0] = s.sw_load;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  // Decode of mapped addresses
  function automatic logic mapped(input logic [7:0] a);
    return a == `RFOC_OFS_CTRL || a == `RFOC_OFS_MUTE || a == `RFOC_OFS_INCFG
        || a == `RFOC_OFS_GAIN || a == `RFOC_OFS_STATUS || a == `RFOC_OFS_SWCMD;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [31:0] wmask;
    logic [31:0] wv;
    logic do_wr;
    logic old_mute;
    logic [2:0] fn;
    wmask = {{8{st_ff.w_strb[3]}}, {8{st_ff.w_strb[2]}},
             {8{st_ff.w_strb[1]}}, {8{st_ff.w_strb[0]}}};
    wv = (rd_val(st_ff.aw_addr, st_ff, sw_status, any_inhibit) & ~wmask)
       | (st_ff.w_data & wmask);
    do_wr = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
    old_mute = st_ff.mute;
    fn = 3'h0;
    nxt_st = st_ff;
    nxt_st.nv_wr = 1'b0;
    nxt_st.inh_prev = any_inhibit;

    // Bus: take address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_val({s_axi_araddr[7:2], 2'b00}, st_ff, sw_status, any_inhibit);
      nxt_st.rresp = mapped({s_axi_araddr[7:2], 2'b00}) ? `RFOC_RESP_OKAY
                                                        : `RFOC_RESP_SLVERR;
    end

    // Power-up: apply stored choice once after reset
    if (!st_ff.init_done) begin
      nxt_st.init_done = 1'b1;
      nxt_st.pwrup = i_nv_pwrup_mode;
      nxt_st.mute_src = rfoc_pkg::SRC_LOCAL;
      case (i_nv_pwrup_mode)
        `RFOC_PWRUP_OPER: nxt_st.mute = 1'b0;
        `RFOC_PWRUP_PREV: nxt_st.mute = i_nv_mute_prev;
        default: nxt_st.mute = 1'b1;
      endcase
      old_mute = nxt_st.mute;
    end else begin
      // Contact mute functions, edge only, ignored in maintenance
      for (int i = 0; i < 4; i++) begin
        fn = st_ff.in_fn[3*i +: 3];
        if (!st_ff.maint) begin
          if ((fn == `RFOC_FN_MUTE || fn == `RFOC_FN_MUTE_LO_UNMUTE_HI) && in_fall[i]) begin
            nxt_st.mute = 1'b1;
            nxt_st.mute_src = rfoc_pkg::SRC_CONTACT;
          end else if (fn == `RFOC_FN_UNMUTE && in_fall[i]) begin
            nxt_st.mute = 1'b0;
          end else if (fn == `RFOC_FN_TOGGLE && in_fall[i]) begin
            nxt_st.mute = ~nxt_st.mute;
            nxt_st.mute_src = rfoc_pkg::SRC_CONTACT;
          end else if (fn == `RFOC_FN_MUTE_LO_UNMUTE_HI && in_rise[i]) begin
            nxt_st.mute = 1'b0;
          end
        end
      end

      // Inhibits cleared in maintenance: force mute
      if (st_ff.maint && st_ff.inh_prev && !any_inhibit) begin
        nxt_st.mute = 1'b1;
        nxt_st.mute_src = rfoc_pkg::SRC_CONTACT;
      end

      // Serial register writes
      if (do_wr) begin
        nxt_st.aw_held = 1'b0;
        nxt_st.w_held = 1'b0;
        nxt_st.bvalid = 1'b1;
        nxt_st.bresp = mapped(st_ff.aw_addr) ? `RFOC_RESP_OKAY : `RFOC_RESP_SLVERR;
        case (st_ff.aw_addr)
          `RFOC_OFS_CTRL: begin
            nxt_st.maint = wv[`RFOC_CTRL_MAINT];
            nxt_st.pwrup = wv[`RFOC_CTRL_PWRUP_LO +: 2];
            nxt_st.buc_fitted = wv[`RFOC_CTRL_BUC];
          end
          `RFOC_OFS_MUTE: begin
            if (!st_ff.maint) begin
              nxt_st.mute = wv[0];
              if (wv[0]) begin
                nxt_st.mute_src = rfoc_pkg::SRC_SERIAL;
              end
            end
          end
          `RFOC_OFS_INCFG: begin
            nxt_st.in_fn = wv[11:0];
            nxt_st.in_low = wv[`RFOC_INCFG_POL_LO +: 4];
          end
          `RFOC_OFS_GAIN: begin
            // Out-of-range request clamps to -20.0 dB
            nxt_st.atten = (wv[7:0] > `RFOC_ATTEN_MAX) ? `RFOC_ATTEN_MAX : wv[7:0];
          end
          `RFOC_OFS_SWCMD: nxt_st.sw_load = wv[0];
          default: nxt_st.bresp = `RFOC_RESP_SLVERR;
        endcase
      end

      // Local panel mute keys win over everything else
      if (i_keys.operate) begin
        nxt_st.mute = 1'b0;
      end else if (i_keys.mute) begin
        nxt_st.mute = 1'b1;
        nxt_st.mute_src = rfoc_pkg::SRC_LOCAL;
      end

      // Gain keys: first press opens screen, later presses step
      case (st_ff.scr)
        rfoc_pkg::SCR_PREVIOUS: begin
          if (i_keys.gain_up || i_keys.gain_down) begin
            nxt_st.scr = rfoc_pkg::SCR_GAIN;
          end
        end
        rfoc_pkg::SCR_GAIN: begin
          if (i_keys.other_key || i_keys.operate || i_keys.mute || gain_tmo) begin
            nxt_st.scr = rfoc_pkg::SCR_PREVIOUS;
          end else if (i_keys.gain_up) begin
            if (st_ff.atten != 8'h00) begin
              nxt_st.atten = st_ff.atten - 8'h01;
            end
          end else if (i_keys.gain_down) begin
            if (st_ff.atten != `RFOC_ATTEN_MAX) begin
              nxt_st.atten = st_ff.atten + 8'h01;
            end
          end
        end
        default: nxt_st.scr = rfoc_pkg::SCR_PREVIOUS;
      endcase
    end

    // Store mute changes when restoring previous state
    if (st_ff.init_done && nxt_st.pwrup == `RFOC_PWRUP_PREV && nxt_st.mute != old_mute) begin
      nxt_st.nv_wr = 1'b1;
      nxt_st.nv_mute = nxt_st.mute;
    end

    // Enable and reason, registered from current conditions
    nxt_st.amp_en = st_ff.init_done && !nxt_st.mute && !any_inhibit && !any_shut;
    if (any_inhibit) begin
      nxt_st.reason = rfoc_pkg::RSN_INHIBIT;
    end else if (i_shut.upconverter_unlock && st_ff.buc_fitted) begin
      nxt_st.reason = rfoc_pkg::RSN_UPCONVERTER_UNLOCK_OFF;
    end else if (i_shut.thermal_shutdown) begin
      nxt_st.reason = rfoc_pkg::RSN_THERMAL_SHUTDOWN;
    end else if (i_shut.interlock_broken) begin
      nxt_st.reason = rfoc_pkg::RSN_INTERLOCK_BROKEN;
    end else if (i_shut.fast_shutoff_short) begin
      nxt_st.reason = rfoc_pkg::RSN_FAST_SHUTOFF_SHORT;
    end else if (i_shut.gate_bias_failure) begin
      nxt_st.reason = rfoc_pkg::RSN_GATE_BIAS_FAILURE;
    end else if (i_shut.overcurrent_shutdown) begin
      nxt_st.reason = rfoc_pkg::RSN_OVERCURRENT_SHUTDOWN;
    end else if (nxt_st.mute) begin
      case (nxt_st.mute_src)
        rfoc_pkg::SRC_SERIAL: nxt_st.reason = rfoc_pkg::RSN_MUTED_BY_SERIAL;
        rfoc_pkg::SRC_CONTACT: nxt_st.reason = rfoc_pkg::RSN_MUTED_BY_CONTACT_INPUT;
        default: nxt_st.reason = rfoc_pkg::RSN_MUTED_LOCAL;
      endcase
    end else if (!nxt_st.amp_en) begin
      nxt_st.reason = rfoc_pkg::RSN_OFF_NO_REASON;
    end else begin
      nxt_st.reason = rfoc_pkg::RSN_OPERATING;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, frozen while clock enable is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st_ff <= '0;
      st_ff.in_fn <= `RFOC_INFN_RST;
      st_ff.in_low <= `RFOC_INPOL_RST;
      st_ff.mute <= 1'b1;
      st_ff.atten <= `RFOC_ATTEN_RST;
      st_ff.scr <= rfoc_pkg::SCR_PREVIOUS;
      st_ff.reason <= rfoc_pkg::RSN_MUTED_LOCAL;
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes
  assign s_axi_awready = i_clk_en & st_ff.init_done & ~st_ff.aw_held & ~st_ff.bvalid;
  assign s_axi_wready = i_clk_en & st_ff.init_done & ~st_ff.w_held & ~st_ff.bvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = i_clk_en & st_ff.init_done & ~st_ff.rvalid;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  ////////////////////////////////////////////////////////////////////////
  // Block outputs
  assign o_amp_enable = st_ff.amp_en;
  assign o_rf_on_led = st_ff.amp_en;
  assign o_show_power = st_ff.amp_en;
  assign o_off_reason = st_ff.reason;
  assign o_mute_led = st_ff.mute;
  assign o_inhibit_contact = ~st_ff.inh_prev;
  assign o_gain_screen = (st_ff.scr == rfoc_pkg::SCR_GAIN);
  assign o_gain_atten = st_ff.atten;
  assign o_switch_to_load = st_ff.sw_load;
  assign o_nv_wr = st_ff.nv_wr;
  assign o_nv_mute = st_ff.nv_mute;

endmodule

/* File: rtl/rfoc_consts.svh */
`ifndef RFOC_CONSTS_SVH
`define RFOC_CONSTS_SVH

// Register byte offsets
`define RFOC_OFS_CTRL 8'h00
`define RFOC_OFS_MUTE 8'h04
`define RFOC_OFS_INCFG 8'h08
`define RFOC_OFS_GAIN 8'h0C
`define RFOC_OFS_STATUS 8'h10
`define RFOC_OFS_SWCMD 8'h14

// Control register fields
`define RFOC_CTRL_MAINT 0
`define RFOC_CTRL_PWRUP_LO 1
`define RFOC_CTRL_BUC 3

// Input config: three function bits per input, polarity bits from here up
`define RFOC_INCFG_POL_LO 16

// Status register fields
`define RFOC_ST_RFON 0
`define RFOC_ST_REASON_LO 1
`define RFOC_ST_SWITCH_LO 5
`define RFOC_ST_INHIBIT 8
`define RFOC_ST_GAINSCR 9
`define RFOC_ST_MUTESRC_LO 10

// Contact input functions
`define RFOC_FN_NONE 3'h0
`define RFOC_FN_INHIBIT 3'h1
`define RFOC_FN_MUTE 3'h2
`define RFOC_FN_UNMUTE 3'h3
`define RFOC_FN_TOGGLE 3'h4
`define RFOC_FN_MUTE_LO_UNMUTE_HI 3'h5

// Power-up behaviour codes
`define RFOC_PWRUP_MUTE 2'h0
`define RFOC_PWRUP_OPER 2'h1
`define RFOC_PWRUP_PREV 2'h2

// Gain: attenuation in 0.1 dB steps, 0 is maximum gain, 200 is -20.0 dB
`define RFOC_ATTEN_MAX 8'hC8
`define RFOC_ATTEN_RST 8'h00

// Reset values
`define RFOC_CTRL_RST 4'h0
`define RFOC_INFN_RST 12'h000
`define RFOC_INPOL_RST 4'h0

// Gain screen timeout: 5 s at 20 MHz
`define RFOC_GAIN_TMO_S 5
`define RFOC_CLK_HZ 20000000

// AXI responses
`define RFOC_RESP_OKAY 2'h0
`define RFOC_RESP_SLVERR 2'h2

`endif

/* File: rtl/rfoc_pkg.sv */
package rfoc_pkg;

  // Off reasons as reported on status
  typedef enum logic [3:0] {
    RSN_OPERATING = 4'h0,
    RSN_INHIBIT = 4'h1,
    RSN_UPCONVERTER_UNLOCK_OFF = 4'h2,
    RSN_THERMAL_SHUTDOWN = 4'h3,
    RSN_INTERLOCK_BROKEN = 4'h4,
    RSN_FAST_SHUTOFF_SHORT = 4'h5,
    RSN_GATE_BIAS_FAILURE = 4'h6,
    RSN_OVERCURRENT_SHUTDOWN = 4'h7,
    RSN_MUTED_LOCAL = 4'h8,
    RSN_MUTED_BY_SERIAL = 4'h9,
    RSN_MUTED_BY_CONTACT_INPUT = 4'hA,
    RSN_OFF_NO_REASON = 4'hB
  } rfoc_reason_t;

  // Output path switch states
  typedef enum logic [2:0] {
    SW_ANTENNA = 3'h0,
    SW_LOAD_POSITION = 3'h1,
    SW_SWITCHING = 3'h2,
    SW_SWITCH_POWER_FAILED = 3'h3,
    SW_DISCONNECTED = 3'h4,
    SW_SWITCH_STATUS_UNREADABLE = 3'h5
  } rfoc_sw_t;

  // Who last set mute
  typedef enum logic [1:0] {
    SRC_LOCAL = 2'h0,
    SRC_SERIAL = 2'h1,
    SRC_CONTACT = 2'h2
  } rfoc_src_t;

  // Display screen, one-hot
  typedef enum logic [1:0] {
    SCR_PREVIOUS = 2'b01,
    SCR_GAIN = 2'b10
  } rfoc_scr_t;

  // Shutdown conditions from the amplifier
  typedef struct packed {
    logic upconverter_unlock;
    logic thermal_shutdown;
    logic interlock_broken;
    logic fast_shutoff_short;
    logic gate_bias_failure;
    logic overcurrent_shutdown;
  } rfoc_shut_t;

  // Raw output path switch sense lines
  typedef struct packed {
    logic hw_error;
    logic present;
    logic power_ok;
    logic at_antenna;
    logic at_load;
  } rfoc_sw_sense_t;

  // Local panel key pulses
  typedef struct packed {
    logic operate;
    logic mute;
    logic gain_up;
    logic gain_down;
    logic other_key;
  } rfoc_keys_t;

  // Contact input conditioner state
  typedef struct packed {
    logic pin;
    logic primed;
  } rfoc_cin_st_t;

  // Idle timer state
  typedef struct packed {
    logic [26:0] cnt;
  } rfoc_tmr_st_t;

  // Main block state
  typedef struct packed {
    logic init_done;
    logic maint;
    logic [1:0] pwrup;
    logic buc_fitted;
    logic [11:0] in_fn;
    logic [3:0] in_low;
    logic mute;
    rfoc_src_t mute_src;
    logic [7:0] atten;
    rfoc_scr_t scr;
    logic sw_load;
    logic inh_prev;
    logic amp_en;
    rfoc_reason_t reason;
    logic nv_wr;
    logic nv_mute;
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } rfoc_st_t;

endpackage

/* File: rtl/rfoc_contact_in.sv */
`timescale 1ns/100ps
`include "rfoc_consts.svh"

module rfoc_contact_in (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_pin,
  input wire logic i_active_low,
  output logic o_active,
  output logic o_fall,
  output logic o_rise
);

  rfoc_pkg::rfoc_cin_st_t st_ff; // Previous pin level
  rfoc_pkg::rfoc_cin_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Next state: remember pin, prime after first sample
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin = i_pin;
    nxt_st.primed = 1'b1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st_ff <= '0;
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level with chosen polarity; edges only once primed
  assign o_active = i_pin ^ i_active_low;
  assign o_fall = i_clk_en & st_ff.primed & st_ff.pin & ~i_pin;
  assign o_rise = i_clk_en & st_ff.primed & ~st_ff.pin & i_pin;

endmodule

/* File: rtl/rfoc_idle_timer.sv */
`timescale 1ns/100ps

module rfoc_idle_timer #(
  parameter logic [26:0] LIMIT = 27'h5F5E100
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire logic i_run,
  input wire logic i_kick,
  output logic o_expired
);

  rfoc_pkg::rfoc_tmr_st_t st_ff; // Idle cycle count
  rfoc_pkg::rfoc_tmr_st_t nxt_st;

  ////////////////////////////////////////////////////////////////////////
  // Count idle cycles while running, restart on any activity
  always_comb begin
    nxt_st = st_ff;
    if (!i_run || i_kick) begin
      nxt_st.cnt = '0;
    end else if (st_ff.cnt != LIMIT) begin
      nxt_st.cnt = st_ff.cnt + 27'h1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st_ff <= '0;
    end else if (i_clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Expiry pulse, one enabled cycle
  assign o_expired = i_clk_en & i_run & ~i_kick & (st_ff.cnt == LIMIT - 27'h1);

endmodule

/* File: test/rfoc_monitor.sv */
`timescale 1ns/100ps
// Port checks on enable, reason and gain
module rfoc_monitor (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire rfoc_pkg::rfoc_keys_t i_keys,
  input wire rfoc_pkg::rfoc_shut_t i_shut,
  input wire logic o_amp_enable,
  input wire logic o_rf_on_led,
  input wire logic o_mute_led,
  input wire logic o_gain_screen,
  input wire logic [3:0] o_off_reason,
  input wire logic [7:0] o_gain_atten
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Any shutdown except upconverter unlock, or a lone gain-up key
  wire sd = i_clk_en && |i_shut[4:0];
  wire up = i_clk_en && i_keys == 5'h04;
  property p_led; o_rf_on_led == (o_off_reason == 4'h0); endproperty
  a_led: assert property (p_led) else $error("led differs");
  property p_on; o_amp_enable |-> o_off_reason == 4'h0; endproperty
  a_on: assert property (p_on) else $error("on with reason");
  property p_off; !o_amp_enable |-> o_off_reason != 4'h0; endproperty
  a_off: assert property (p_off) else $error("off without reason");
  property p_mute; o_mute_led |-> !o_amp_enable; endproperty
  a_mute: assert property (p_mute) else $error("on while muted");
  property p_shut; sd |=> !o_amp_enable && o_off_reason inside {[1:7]}; endproperty
  a_shut: assert property (p_shut) else $error("on in shutdown");
  property p_max; o_gain_atten <= 8'hC8; endproperty
  a_max: assert property (p_max) else $error("gain out of range");
  property p_step;
    up && o_gain_screen |=> o_gain_atten ==
      ($past(o_gain_atten) == 8'h00 ? 8'h00 : $past(o_gain_atten) - 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("bad gain step");
  property p_open; up && !o_gain_screen |=> o_gain_screen && $stable(o_gain_atten); endproperty
  a_open: assert property (p_open) else $error("first press moved gain");
  c_on: cover property (o_amp_enable);
  c_scr: cover property (o_gain_screen);
  c_sd: cover property (sd ##1 !o_amp_enable);
endmodule
bind rfoc_core rfoc_monitor mon_u (.i_ref_clk, .i_reset_n, .i_clk_en, .i_keys, .i_shut,
  .o_amp_enable, .o_rf_on_led, .o_mute_led, .o_gain_screen, .o_off_reason, .o_gain_atten);

/* File: test/rfoc_switch_model.sv */
`timescale 1ns/100ps
// Output path switch: travels, then closes one contact
module rfoc_switch_model #(
  parameter int TRAVEL = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_cmd_load,
  input wire logic i_pwr_fail,
  output rfoc_pkg::rfoc_sw_sense_t o_sense
);
  int cnt = 0;
  logic pos = 0;
  // Moves only while powered
  always @(posedge i_ref_clk) begin
    if (i_cmd_load != pos && !i_pwr_fail) begin
      cnt <= cnt + 1;
      if (cnt == TRAVEL) begin
        pos <= i_cmd_load;
        cnt <= 0;
      end
    end
  end
  // Both contacts open mid-travel
  assign o_sense = {2'b01, !i_pwr_fail, cnt == 0 && !pos, cnt == 0 && pos};
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic i_ref_clk = 0, i_reset_n = 0, i_clk_en = 1, i_nv_mute_prev = 0, pf = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, o_amp_enable, o_rf_on_led, o_mute_led, o_inhibit_contact;
  logic o_show_power, o_gain_screen, o_switch_to_load, o_nv_wr, o_nv_mute;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, o_gain_atten;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF, i_contact_in = 4'hF, o_off_reason;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, i_nv_pwrup_mode = 0;
  rfoc_pkg::rfoc_keys_t i_keys = '0;
  rfoc_pkg::rfoc_shut_t i_shut = '0;
  rfoc_pkg::rfoc_sw_sense_t i_sw_sense;
  int n_errors = 0, checks_done = 0, nvw = 0, i;
  rfoc_core #(.GAIN_TMO_CYC(27'd50)) dut_u (.*);
  rfoc_switch_model sw_u (.i_ref_clk, .i_cmd_load(o_switch_to_load), .i_pwr_fail(pf),
    .o_sense(i_sw_sense));
  initial forever #25 i_ref_clk = ~i_ref_clk;
  // Count stored mute writes
  always @(posedge i_ref_clk) nvw <= nvw + o_nv_wr;
  task tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %0h seen %0h", s, e, g);
    end
  endtask
  // Settle, then check enable and reason
  task ex(input logic [3:0] r);
    tick(3);
    chk("reason", {28'h0, r}, {28'h0, o_off_reason});
    chk("rf_on", {31'h0, r == 4'h0}, {31'h0, o_amp_enable});
    chk("show", {31'h0, r == 4'h0}, {31'h0, o_show_power});
  endtask
  task key(input logic [4:0] k);
    i_keys <= k;
    tick(1);
    i_keys <= '0;
    tick(2);
  endtask
  // Write: both channels offered, each released when taken
  task aw_wr(input logic [7:0] a, input logic [31:0] d);
    bit done;
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    done = 0;
    while (!done) begin
      @(posedge i_ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      done = s_axi_bvalid;
    end
    s_axi_bready <= 0;
    resp = s_axi_bresp;
    tick(1);
  endtask
  task ax_rd(input logic [7:0] a);
    bit done;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    done = 0;
    while (!done) begin
      @(posedge i_ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      done = s_axi_rvalid;
    end
    s_axi_rready <= 0;
    {rdat, resp} = {s_axi_rdata, s_axi_rresp};
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(8);
    i_reset_n <= 1;
    ex(4'h8);
    aw_wr(8'h04, 0);
    ex(4'h0);
    aw_wr(8'h04, 1);
    ex(4'h9);
    aw_wr(8'h04, 0);
    // Input 0 inhibit low, 1 toggle, 2 mute fall/unmute rise
    aw_wr(8'h08, 32'h0001_0161);
    i_contact_in <= 4'hE;
    ex(4'h1);
    chk("inh_contact", 0, o_inhibit_contact);
    i_contact_in <= 4'hF;
    ex(4'h0);
    chk("inh_contact", 1, o_inhibit_contact);
    i_contact_in <= 4'hB;
    ex(4'hA);
    i_contact_in <= 4'hF;
    ex(4'h0);
    i_contact_in <= 4'hD;
    ex(4'hA);
    i_contact_in <= 4'hF;
    ex(4'hA);
    key(5'h10);
    ex(4'h0);
    // Maintenance mode
    aw_wr(8'h00, 1);
    i_contact_in <= 4'hE;
    ex(4'h1);
    i_contact_in <= 4'hF;
    ex(4'hA);
    aw_wr(8'h04, 0);
    ex(4'hA);
    key(5'h10);
    ex(4'h0);
    aw_wr(8'h00, 0);
    for (i = 0; i < 5; i++) begin
      i_shut <= 6'(1 << i);
      ex(4'(7 - i));
    end
    i_shut <= 6'h20;
    ex(4'h0);
    aw_wr(8'h00, 8);
    ex(4'h2);
    i_shut <= '0;
    aw_wr(8'h0C, 2);
    key(5'h04);
    chk("screen", 1, o_gain_screen);
    chk("atten", 2, o_gain_atten);
    repeat (3) key(5'h04);
    chk("atten", 0, o_gain_atten);
    key(5'h02);
    chk("atten", 1, o_gain_atten);
    tick(60);
    chk("screen", 0, o_gain_screen);
    key(5'h04);
    key(5'h01);
    chk("screen", 0, o_gain_screen);
    aw_wr(8'h0C, 32'hFF);
    ax_rd(8'h0C);
    chk("gain_reg", 8'hC8, rdat[7:0]);
    aw_wr(8'h14, 1);
    tick(10);
    ax_rd(8'h10);
    chk("switch", 1, rdat[7:5]);
    pf <= 1;
    tick(3);
    ax_rd(8'h10);
    chk("switch", 3, rdat[7:5]);
    pf <= 0;
    aw_wr(8'h00, 4);
    i = nvw;
    aw_wr(8'h04, 1);
    chk("nv_mute", 1, o_nv_mute);
    aw_wr(8'h04, 0);
    tick(3);
    chk("nv_writes", i + 2, nvw);
    ax_rd(8'h40);
    chk("rresp", 2, resp);
    aw_wr(8'h40, 0);
    chk("bresp", 2, resp);
    wrap_up;
  end
  // Watchdog
  initial begin
    #1000000;
    n_errors++;
    wrap_up;
  end
endmodule
